/* File: peu_pkg.sv */
// package for the event unit interrupt status block
// assumes a plain strobed register port with 32-bit data
`default_nettype none
package peu_pkg;
	localparam int          PEU_ADDR_W          = 12;
	localparam logic [11:0] PEU_OFF_INDEX       = 12'h520;
	localparam logic [11:0] PEU_OFF_IRQ_STATUS  = 12'h528;
	localparam logic [11:0] PEU_OFF_CTRL_STATUS = 12'h52C;
	localparam logic [11:0] PEU_OFF_NOTIFY      = 12'h540;
	localparam int          PEU_NUM_TRIG        = 3;
	localparam int          PEU_NUM_STAMP       = 2;
	localparam int          PEU_TRIG_LSB        = 16;
	localparam int          PEU_STAMP_LSB       = 0;
	localparam int          PEU_IDX_STAMP_BIT   = 8;
	localparam int          PEU_CS_TRIG_EN_BIT  = 3;
	localparam int          PEU_CS_TRIG_ACT_BIT = 4;
	localparam int          PEU_CS_IRQ_EN_BIT   = 5;
	localparam int          PEU_CS_STAMP_EN_BIT = 1;
	localparam logic [31:0] PEU_STATUS_MASK     = 32'h0007_0003;
	localparam logic [31:0] PEU_RESET_WORD      = 32'h0000_0000;
	localparam logic [1:0]  PEU_IDX_RESET       = 2'h0;
	typedef enum logic [2:0]
	{
		PEU_RD_IDLE = 3'b001,
		PEU_RD_DATA = 3'b010,
		PEU_RD_MISS = 3'b100
	} peu_rd_e;
endpackage
`default_nettype wire

/* File: peu_sticky.sv */
// one sticky write-clear status bit with its own enable
// assumes events are one-cycle pulses synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module peu_sticky
	import peu_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic event_in,
	input  wire logic enable,
	input  wire logic clear,
	output var  logic flag
);
	logic flag_reg;
	logic flag_next;

	// set wins over clear
	always_comb
	begin
		flag_next = flag_reg;
		if (clear)
			flag_next = 1'b0;
		if (event_in && enable)
			flag_next = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	assign flag = flag_reg;

	a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
		event_in && enable |=> flag)
		else $error("enabled event lost");
	a_no_set_disabled: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!flag && !(event_in && enable) |=> !flag)
		else $error("flag rose without enabled event");
endmodule
`default_nettype wire

/* File: peu_index.sv */
// unit index pointer register: trigger index and stamp index
// assumes write strobe decoded by the parent
`timescale 1ns/10ps
`default_nettype none
module peu_index
	import peu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	output var  logic [1:0]  trig_sel,
	output var  logic        stamp_sel
);
	logic [1:0] trig_reg;
	logic       stamp_reg;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			trig_reg  <= PEU_IDX_RESET;
			stamp_reg <= 1'b0;
		end
		else if (wr_en)
		begin
			trig_reg  <= wr_data[1:0];
			stamp_reg <= wr_data[PEU_IDX_STAMP_BIT];
		end
	end

	assign trig_sel  = trig_reg;
	assign stamp_sel = stamp_reg;
endmodule
`default_nettype wire

/* File: peu_irq_status.sv */
// event unit interrupt status collector with indexed control/status
// assumes one-cycle event pulses on ref_clk and a never-waiting slave port
`timescale 1ns/10ps
`default_nettype none
module peu_irq_status
	import peu_pkg::*;
#(
	parameter int NUM_TRIG  = PEU_NUM_TRIG,
	parameter int NUM_STAMP = PEU_NUM_STAMP
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic [PEU_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output var  logic [31:0]           reg_rdata,
	input  wire logic [NUM_TRIG-1:0]   trig_event,
	input  wire logic [NUM_TRIG-1:0]   trig_done,
	input  wire logic [NUM_STAMP-1:0]  stamp_event,
	output var  logic [NUM_TRIG-1:0]   trig_enable,
	output var  logic [NUM_STAMP-1:0]  stamp_enable,
	output var  logic                  gpio_event_summary
);
	////////////////////////////////////////////////////////////////
	// decode
	logic wr_status;
	logic wr_ctrl;
	logic wr_index;
	logic wr_notify;

	assign wr_status = reg_wr && (reg_addr == PEU_OFF_IRQ_STATUS);
	assign wr_ctrl   = reg_wr && (reg_addr == PEU_OFF_CTRL_STATUS);
	assign wr_index  = reg_wr && (reg_addr == PEU_OFF_INDEX);
	assign wr_notify = reg_wr && (reg_addr == PEU_OFF_NOTIFY);

	logic [1:0] trig_sel;
	logic       stamp_sel;

	peu_index u_index
	(
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.wr_en     (wr_index),
		.wr_data   (reg_wdata),
		.trig_sel  (trig_sel),
		.stamp_sel (stamp_sel)
	);

	////////////////////////////////////////////////////////////////
	// per-unit control bits
	logic [NUM_TRIG-1:0]  notify_on_trigger_reg;
	logic [NUM_TRIG-1:0]  trig_en_reg;
	logic [NUM_STAMP-1:0] stamp_irq_enable_reg;
	logic [NUM_STAMP-1:0] stamp_en_reg;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			notify_on_trigger_reg <= '0;
		else if (wr_notify)
			notify_on_trigger_reg <= reg_wdata[NUM_TRIG-1:0];
	end

	genvar t;
	generate
		for (t = 0; t < NUM_TRIG; t++)
		begin : g_trig_ctl
			// enable self-clears when the unit finishes unless a same-cycle control write to this unit wins
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
					trig_en_reg[t] <= 1'b0;
				else if (wr_ctrl && trig_sel == 2'(t))
					trig_en_reg[t] <= reg_wdata[PEU_CS_TRIG_EN_BIT];
				else if (trig_done[t])
					trig_en_reg[t] <= 1'b0;
			end
		end
	endgenerate

	genvar s;
	generate
		for (s = 0; s < NUM_STAMP; s++)
		begin : g_stamp_ctl
			always_ff @(posedge ref_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					stamp_irq_enable_reg[s] <= 1'b0;
					stamp_en_reg[s]         <= 1'b0;
				end
				else if (wr_ctrl && stamp_sel == 1'(s))
				begin
					stamp_irq_enable_reg[s] <= reg_wdata[PEU_CS_IRQ_EN_BIT];
					stamp_en_reg[s]         <= reg_wdata[PEU_CS_STAMP_EN_BIT];
				end
			end
		end
	endgenerate

	assign trig_enable  = trig_en_reg;
	assign stamp_enable = stamp_en_reg;

	////////////////////////////////////////////////////////////////
	// sticky status bits
	logic [NUM_TRIG-1:0]  trig_flag;
	logic [NUM_STAMP-1:0] stamp_flag;

	generate
		for (t = 0; t < NUM_TRIG; t++)
		begin : g_trig_flag
			peu_sticky u_flag
			(
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.event_in (trig_event[t]),
				.enable   (notify_on_trigger_reg[t]),
				.clear    (wr_status && reg_wdata[PEU_TRIG_LSB+t]),
				.flag     (trig_flag[t])
			);
		end
		for (s = 0; s < NUM_STAMP; s++)
		begin : g_stamp_flag
			// only GPIO input stamp events feed these bits
			peu_sticky u_flag
			(
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.event_in (stamp_event[s]),
				.enable   (stamp_irq_enable_reg[s]),
				.clear    (wr_status && reg_wdata[PEU_STAMP_LSB+s]),
				.flag     (stamp_flag[s])
			);
		end
	endgenerate

	logic [31:0] status_word;

	always_comb
	begin
		status_word = PEU_RESET_WORD;
		status_word[PEU_TRIG_LSB +: NUM_TRIG]   = trig_flag;
		status_word[PEU_STAMP_LSB +: NUM_STAMP] = stamp_flag;
		status_word = status_word & PEU_STATUS_MASK;
	end

	assign gpio_event_summary = |status_word;

	////////////////////////////////////////////////////////////////
	// read path, data one cycle after strobe
	logic [31:0] ctrl_word;

	always_comb
	begin
		ctrl_word = PEU_RESET_WORD;
		ctrl_word[PEU_CS_IRQ_EN_BIT]   = stamp_irq_enable_reg[stamp_sel];
		ctrl_word[PEU_CS_STAMP_EN_BIT] = stamp_en_reg[stamp_sel];
		if (trig_sel < NUM_TRIG[1:0])
		begin
			ctrl_word[PEU_CS_TRIG_EN_BIT]  = trig_en_reg[trig_sel];
			ctrl_word[PEU_CS_TRIG_ACT_BIT] = trig_en_reg[trig_sel];
		end
	end

	peu_rd_e     rd_state_reg;
	logic [31:0] rdata_reg;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rd_state_reg <= PEU_RD_IDLE;
		else if (!reg_rd)
			rd_state_reg <= PEU_RD_IDLE;
		else
			case (reg_addr)
				PEU_OFF_IRQ_STATUS,
				PEU_OFF_CTRL_STATUS,
				PEU_OFF_INDEX,
				PEU_OFF_NOTIFY: rd_state_reg <= PEU_RD_DATA;
				default:        rd_state_reg <= PEU_RD_MISS;
			endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_reg <= PEU_RESET_WORD;
		else if (reg_rd)
			case (reg_addr)
				PEU_OFF_IRQ_STATUS:  rdata_reg <= status_word;
				PEU_OFF_CTRL_STATUS: rdata_reg <= ctrl_word;
				PEU_OFF_INDEX:       rdata_reg <= {23'h0, stamp_sel, 6'h0, trig_sel};
				PEU_OFF_NOTIFY:      rdata_reg <= {{(32-NUM_TRIG){1'b0}}, notify_on_trigger_reg};
				default:             rdata_reg <= PEU_RESET_WORD;
			endcase
		else
			rdata_reg <= PEU_RESET_WORD;
	end

	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////
	// checks
	a_trig_bit_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
		trig_event[0] && notify_on_trigger_reg[0] |=> status_word[PEU_TRIG_LSB])
		else $error("trigger unit 0 not at bit 16");
	a_trig_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!notify_on_trigger_reg[1] && !trig_flag[1] |=> !trig_flag[1])
		else $error("trigger flag set while notify off");
	a_stamp_bit_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stamp_event[1] && stamp_irq_enable_reg[1] |=> status_word[1])
		else $error("stamp unit 1 not at bit 1");
	a_stamp_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!stamp_irq_enable_reg[0] && !stamp_flag[0] |=> !stamp_flag[0])
		else $error("stamp flag set while disabled");
	a_summary_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
		gpio_event_summary == ((|trig_flag) || (|stamp_flag)))
		else $error("summary not OR of flags");
	a_trig_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_status && reg_wdata[PEU_TRIG_LSB] && !trig_event[0] |=> !trig_flag[0])
		else $error("trigger flag not cleared");
	a_stamp_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_status && reg_wdata[0] && !stamp_event[0] |=> !stamp_flag[0])
		else $error("stamp flag not cleared");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(reg_rd) && $past(reg_addr) == PEU_OFF_IRQ_STATUS |-> (reg_rdata & ~PEU_STATUS_MASK) == 32'h0)
		else $error("reserved bits read nonzero");
	a_index_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_ctrl && stamp_sel |=> stamp_irq_enable_reg[1] == $past(reg_wdata[PEU_CS_IRQ_EN_BIT]))
		else $error("indexed write missed unit 1");
	a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data held beyond one cycle");

	// read port bookkeeping: misses and idle cycles read zero
	a_rd_onehot: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$onehot(rd_state_reg))
		else $error("read state not one-hot");
	a_rd_miss_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_state_reg == PEU_RD_MISS |-> reg_rdata == 32'h0)
		else $error("unmapped read returned data");
	a_rd_idle_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_state_reg == PEU_RD_IDLE |-> reg_rdata == 32'h0)
		else $error("idle read port not zero");

	// control/status writes land only in the indexed unit; notify writes load all trigger units at once
	a_notify_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_notify |=> notify_on_trigger_reg == $past(reg_wdata[NUM_TRIG-1:0]))
		else $error("notify bits not written");
	a_index_unit0: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_ctrl && !stamp_sel |=> stamp_irq_enable_reg[0] == $past(reg_wdata[PEU_CS_IRQ_EN_BIT]))
		else $error("indexed write missed unit 0");
	a_stamp_en_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_ctrl && stamp_sel |=> stamp_en_reg[1] == $past(reg_wdata[PEU_CS_STAMP_EN_BIT]))
		else $error("stamp enable write missed unit 1");
	a_trig_idx_none: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_ctrl && trig_sel == 2'h3 && !(|trig_done) |=> trig_en_reg == $past(trig_en_reg))
		else $error("reserved trigger index changed an enable");
	a_summary_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		|(stamp_event & stamp_irq_enable_reg) |=> gpio_event_summary)
		else $error("summary missed a stamp event");

	// per-unit checks; done clears the enable unless a same-unit control write wins
	generate
		for (t = 0; t < NUM_TRIG; t++)
		begin : g_trig_chk
			a_trig_done_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
				trig_done[t] && !(wr_ctrl && trig_sel == 2'(t)) |=> !trig_en_reg[t])
				else $error("trigger enable not cleared on done");
			a_trig_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
				wr_status && reg_wdata[PEU_TRIG_LSB+t] && !trig_event[t] |=> !trig_flag[t])
				else $error("trigger flag not cleared");
		end
		for (s = 0; s < NUM_STAMP; s++)
		begin : g_stamp_chk
			a_stamp_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
				wr_status && reg_wdata[PEU_STAMP_LSB+s] && !stamp_event[s] |=> !stamp_flag[s])
				else $error("stamp flag not cleared");
		end
	endgenerate

	c_trig_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(trig_flag[2]));
	c_stamp_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(stamp_flag[1]));
	c_set_clear: cover property (@(posedge ref_clk) disable iff (!rst_b)
		wr_status && reg_wdata[PEU_TRIG_LSB] && trig_event[0] && notify_on_trigger_reg[0]);
	c_summary: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(gpio_event_summary));
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the event unit interrupt status block
// assumes the design's strobed register port and its package constants
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top
	import peu_pkg::*;
;
	logic        ref_clk;
	logic        rst_b;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [2:0]  trig_event;
	logic [2:0]  trig_done;
	logic [1:0]  stamp_event;
	logic [2:0]  trig_enable;
	logic [1:0]  stamp_enable;
	logic        gpio_event_summary;
	int          num_errors;
	int          n_tests;
	logic        live;
	logic [31:0] seed;
	logic [31:0] st_m;
	logic [31:0] exp_rd;
	logic [31:0] exp_mk;
	logic [31:0] set_m;
	logic [2:0]  ntf_m;
	logic [2:0]  ten_m;
	logic [1:0]  sen_m;
	logic [1:0]  sirq_m;
	logic [1:0]  it_m;
	logic        is_m;
	logic        tv;
	logic        chk_rd;

	peu_irq_status peu_irq_status_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trig_event(trig_event), .trig_done(trig_done), .stamp_event(stamp_event),
		.trig_enable(trig_enable), .stamp_enable(stamp_enable), .gpio_event_summary(gpio_event_summary));

	always #2 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	// reference model, updated on the edge the design takes inputs
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			{st_m, ntf_m, ten_m, sen_m, sirq_m, it_m, is_m, chk_rd} = '0;
		end
		else
		begin
			tv = (it_m == 2'h3) ? 1'b0 : ten_m[it_m];
			chk_rd = reg_rd;
			exp_mk = 32'hFFFFFFFF;
			case (reg_addr)
				PEU_OFF_INDEX: exp_rd = {23'h0, is_m, 6'h0, it_m};
				PEU_OFF_IRQ_STATUS: exp_rd = st_m;
				PEU_OFF_NOTIFY: exp_rd = {29'h0, ntf_m};
				PEU_OFF_CTRL_STATUS:
				begin
					exp_rd = {26'h0, sirq_m[is_m], tv, tv, 1'b0, sen_m[is_m], 1'b0};
					exp_mk = 32'h0000_003A;
				end
				default: exp_rd = 32'h0;
			endcase
			set_m = {13'h0, trig_event & ntf_m, 14'h0, stamp_event & sirq_m};
			if (reg_wr)
			begin
				case (reg_addr)
					PEU_OFF_INDEX: {is_m, it_m} = {reg_wdata[8], reg_wdata[1:0]};
					PEU_OFF_IRQ_STATUS: st_m = st_m & ~(reg_wdata & 32'h0007_0003);
					PEU_OFF_NOTIFY: ntf_m = reg_wdata[2:0];
					PEU_OFF_CTRL_STATUS:
					begin
						if (it_m != 2'h3) ten_m[it_m] = reg_wdata[3];
						{sirq_m[is_m], sen_m[is_m]} = {reg_wdata[5], reg_wdata[1]};
					end
					default: ;
				endcase
			end
			ten_m = ten_m & ~trig_done;
			st_m = st_m | set_m;
		end
	end

	always @(negedge ref_clk)
	begin
		if (rst_b && live)
		begin
			`CHK("summary", |st_m, gpio_event_summary)
			`CHK("trig_enable", ten_m, trig_enable)
			`CHK("stamp_enable", sen_m, stamp_enable)
			if (chk_rd) `CHK("rdata", exp_rd, reg_rdata & exp_mk)
		end
	end

	////////////////////////////////////////////////////////////////
	// bus and event tasks
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic pulse(input logic [2:0] t, input logic [1:0] s, input logic [2:0] d);
		@(posedge ref_clk);
		{trig_event, stamp_event, trig_done} <= {t, s, d};
		@(posedge ref_clk);
		{trig_event, stamp_event, trig_done} <= '0;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		num_errors++;
		results();
	end

	////////////////////////////////////////////////////////////////
	// directed scenarios, then random traffic
	initial
	begin
		{ref_clk, rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, live} = '0;
		{trig_event, trig_done, stamp_event, num_errors, n_tests} = '0;
		seed = 32'h4DCA;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		live = 1'b1;
		foreach (st_m[i]) if (i < 7) rd(12'h520 + 12'(i * 4) + ((i > 4) ? 12'h014 : 12'h0));
		$display("test reset_and_unmapped done");
		pulse(3'h7, 2'h3, 3'h0);
		rd(PEU_OFF_IRQ_STATUS);
		$display("test gated_events done");
		for (int t = 0; t < 3; t++)
		begin
			wr(PEU_OFF_NOTIFY, 32'h1 << t);
			pulse(3'h7, 2'h0, 3'h0);
			rd(PEU_OFF_IRQ_STATUS);
			wr(PEU_OFF_IRQ_STATUS, 32'hFFFFFFFF);
			rd(PEU_OFF_IRQ_STATUS);
		end
		$display("test trigger_status done");
		for (int s = 0; s < 2; s++)
		begin
			wr(PEU_OFF_INDEX, 32'h100 * s);
			wr(PEU_OFF_CTRL_STATUS, 32'h22);
			rd(PEU_OFF_CTRL_STATUS);
			pulse(3'h0, 2'h3, 3'h0);
			rd(PEU_OFF_IRQ_STATUS);
			wr(PEU_OFF_IRQ_STATUS, 32'h1 << s);
			rd(PEU_OFF_IRQ_STATUS);
		end
		$display("test stamp_status done");
		for (int t = 0; t < 4; t++)
		begin
			wr(PEU_OFF_INDEX, t);
			wr(PEU_OFF_CTRL_STATUS, 32'h08);
			rd(PEU_OFF_CTRL_STATUS);
			rd(PEU_OFF_INDEX);
		end
		pulse(3'h0, 2'h0, 3'h2);
		$display("test trigger_index done");
		repeat (1500)
		begin
			@(posedge ref_clk);
			seed = xs(seed);
			trig_event <= seed[2:0] & {3{seed[3]}};
			stamp_event <= seed[5:4];
			reg_rd <= seed[14];
			reg_wr <= !seed[14] && seed[15];
			trig_done <= (!seed[14] && seed[15]) ? 3'h0 : seed[8:6] & {3{seed[9] & seed[10]}};
			reg_addr <= seed[13] ? PEU_OFF_NOTIFY : 12'h520 + {8'h0, seed[12:11], 2'b00};
			reg_wdata <= xs(seed ^ 32'h1234);
		end
		@(posedge ref_clk);
		{trig_event, stamp_event, trig_done, reg_rd, reg_wr} <= '0;
		repeat (3) @(posedge ref_clk);
		$display("test random_traffic done");
		results();
	end
endmodule
`default_nettype wire
